/* hdl/tmc_map.vh */
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
// Register byte offsets on the AXI4-Lite port.
`define TMC_OFS_MODE0     8'h00
`define TMC_OFS_MODE1     8'h04
`define TMC_OFS_MODE2     8'h08
`define TMC_OFS_MODE3     8'h0C
`define TMC_OFS_MODE4     8'h10
`define TMC_OFS_IOH0      8'h20
`define TMC_OFS_IOL0      8'h24
`define TMC_OFS_IO1       8'h28
`define TMC_OFS_IO2       8'h2C
`define TMC_OFS_IOH3      8'h30
`define TMC_OFS_IOL3      8'h34
`define TMC_OFS_IOH4      8'h38
`define TMC_OFS_IOL4      8'h3C
`define TMC_OFS_CLKSEL4   8'h40
`define TMC_OFS_STATUS4   8'h44
// Reset values.
`define TMC_MODE_RST      8'hC0
`define TMC_IO_RST        8'h00
`define TMC_CLKSEL_RST    3'h0
// Field positions.
`define TMC_BIT_BUF_SECOND 5
`define TMC_BIT_BUF_FIRST  4
`define TMC_MODE_FIXED     8'hC0
// Mode codes.
`define TMC_MD_NORMAL     4'h0
`define TMC_MD_PWM1       4'h2
`define TMC_MD_PWM2       4'h3
`define TMC_MD_PHASE1     4'h4
`define TMC_MD_RSYNC      4'h8
`define TMC_MD_CPWM1      4'hD
`define TMC_MD_CPWM2      4'hE
`define TMC_MD_CPWM3      4'hF
// Prescaler divisor exponents of two (largest divisor is 2 to the power 10, 1024).
`define TMC_PRESC_MAX     10
// AXI responses.
`define TMC_RESP_OKAY     2'h0
`define TMC_RESP_SLVERR   2'h2
`endif

/* hdl/tmc_top.v */
// Notes on behaviour
// R1 - Channel four clock select: codes 0-5 internal divide 1..1024, 6 input A, 7 input B.
// R2 - Five channels each own an 8-bit readable, writable mode register.
// R3 - Mode registers reset to C0 on power-on or standby; manual reset leaves them.
// R4 - Mode bits 7 and 6 always read one; writes to them do nothing.
// R5 - Bit 5 set makes fourth register buffer the second; fourth then never matches.
// R6 - Bit 4 set makes third register buffer the first; third then never matches.
// R7 - Channels one and two read buffer bits as zero and ignore writes.
// R8 - Mode field: 0 normal, 2/3 PWM, 4-7 phase counting, 8 reset-sync PWM.
// R9 - Codes D, E, F complementary PWM transferring at peak, valley, or both.
// R10 - Software never writes reserved mode codes 1, 9, A, B, C.
// R11 - Software never programs PWM mode 2 on channels three or four.
// R12 - Software never programs phase counting on channels zero, three or four.
// R13 - Channel three in reset-sync or complementary PWM makes channel four follow it.
// R14 - Software writes reset-sync or complementary codes only on channel three.
// R15 - Pin function registers: high and low for channels 0,3,4; one for 1,2.
// R16 - Pin function registers are 8 bits, reset zero on power-on or standby.
// R17 - High or only register: bits 7-4 second register, bits 3-0 first register.
// R18 - Low register: bits 7-4 fourth register, bits 3-0 third register.
// R19 - A buffering third or fourth register ignores its pin function field.
// R20 - Function codes 0xxx output compare, 1xxx input capture with edge choice.
// R21 - A buffering third or fourth register never clears the counter.
// R22 - Configuration changes take effect from the next count-clock edge.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "tmc_map.vh"
module tmc_top (
    // Clock, reset, enable, standby.
    input  wire        REF_CLK,
    input  wire        RESET_N,
    input  wire        CLK_EN,
    input  wire        STANDBY,
    // AXI4-Lite write address.
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    // AXI4-Lite write data.
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    // AXI4-Lite write response.
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    // AXI4-Lite read address.
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    // AXI4-Lite read data.
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    // External count inputs for channel four.
    input  wire        EXT_COUNT_IN_A,
    input  wire        EXT_COUNT_IN_B,
    // Channel four count enable and effective configuration.
    output reg         CH4_COUNT_TICK,
    output reg  [3:0]  CH4_EFF_MODE,
    output reg  [1:0]  CH4_EFF_BUF,
    // Per-register function codes in effect, channel-major, four bits each.
    output reg  [79:0] EFF_FUNC,
    // Compare match and counter clear permitted per register (A,B,C,D per channel).
    output reg  [19:0] MATCH_ALLOWED,
    output reg  [19:0] CLEAR_ALLOWED,
    // Decoded channel modes, one-hot class per channel.
    output reg  [4:0]  CH_PWM,
    output reg  [4:0]  CH_PHASE,
    output reg  [4:0]  CH_CPWM
);

    localparam ST_IDLE = 3'b001;
    localparam ST_RESP = 3'b010;
    localparam ST_HOLD = 3'b100;

    // Reset synchroniser and pin synchronisers.
    reg  [1:0]  rst_sync;
    wire        rst_n = rst_sync[1];
    reg  [1:0]  ext_a_sync;
    reg  [1:0]  ext_b_sync;
    reg         ext_a_prev;
    reg         ext_b_prev;

    // Register storage; power-on clears all of it, standby all but presc_cnt, nothing else does.
    reg  [5:0]  mode_store [0:4];
    reg  [7:0]  io_high [0:4];
    reg  [7:0]  io_low  [0:4];
    reg  [2:0]  count_source_sel;
    reg  [9:0]  presc_cnt;

    // Write channel state.
    reg  [2:0]  wr_state;
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    integer     i;

    function is_io_high_slot;
        input [7:0] a;
        begin
            is_io_high_slot = (a == `TMC_OFS_IOH0) || (a == `TMC_OFS_IO1) ||
                              (a == `TMC_OFS_IO2)  || (a == `TMC_OFS_IOH3) ||
                              (a == `TMC_OFS_IOH4);
        end
    endfunction

    // Channel index of an address within the io block.
    function [2:0] io_chan;
        input [7:0] a;
        begin
            case (a)
                `TMC_OFS_IOH0, `TMC_OFS_IOL0: io_chan = 3'h0;
                `TMC_OFS_IO1:                 io_chan = 3'h1;
                `TMC_OFS_IO2:                 io_chan = 3'h2;
                `TMC_OFS_IOH3, `TMC_OFS_IOL3: io_chan = 3'h3;
                default:                      io_chan = 3'h4;
            endcase
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'h0) &&
                     ((a <= `TMC_OFS_MODE4) || (a >= `TMC_OFS_IOH0 &&
                      a <= `TMC_OFS_STATUS4));
        end
    endfunction

    // Mode register read value with fixed bits.
    function [7:0] mode_view;
        input [2:0] ch;
        input [5:0] v;
        begin
            if (ch == 3'h1 || ch == 3'h2)
                mode_view = `TMC_MODE_FIXED | {4'h0, v[3:0]}; // R7
            else
                mode_view = `TMC_MODE_FIXED | {2'h0, v}; // R4
        end
    endfunction

    function [31:0] read_value;
        input [7:0] a;
        begin
            read_value = 32'h0;
            if (a <= `TMC_OFS_MODE4)
                read_value = {24'h0, mode_view(a[4:2], mode_store[a[4:2]])};
            else if (a == `TMC_OFS_CLKSEL4)
                read_value = {29'h0, count_source_sel};
            else if (a == `TMC_OFS_STATUS4)
                read_value = {18'h0, CH4_EFF_BUF, CH4_EFF_MODE, 8'h0};
            else if (is_io_high_slot(a))
                read_value = {24'h0, io_high[io_chan(a)]};
            else
                read_value = {24'h0, io_low[io_chan(a)]};
        end
    endfunction

    wire wr_go = aw_held && w_held && (wr_state == ST_IDLE);

    // Readies drop while the enable is low, so no beat is taken that frozen logic would miss.
    assign S_AXI_AWREADY = CLK_EN && (wr_state == ST_IDLE) && !aw_held;
    assign S_AXI_WREADY  = CLK_EN && (wr_state == ST_IDLE) && !w_held;
    assign S_AXI_ARREADY = CLK_EN && !S_AXI_RVALID;

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // Write path: address and data taken in either order, then answered.
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_state         <= ST_IDLE;
            aw_held          <= 1'b0;
            w_held           <= 1'b0;
            aw_addr          <= 8'h0;
            w_data           <= 32'h0;
            w_strb           <= 4'h0;
            S_AXI_BVALID     <= 1'b0;
            S_AXI_BRESP      <= `TMC_RESP_OKAY;
            count_source_sel <= `TMC_CLKSEL_RST;
            for (i = 0; i < 5; i = i + 1) begin
                mode_store[i] <= 6'h0; // R3
                io_high[i]    <= `TMC_IO_RST; // R16
                io_low[i]     <= `TMC_IO_RST;
            end
        end else if (CLK_EN) begin
            if (STANDBY) begin
                count_source_sel <= `TMC_CLKSEL_RST;
                for (i = 0; i < 5; i = i + 1) begin
                    mode_store[i] <= 6'h0; // R3
                    io_high[i]    <= `TMC_IO_RST; // R16
                    io_low[i]     <= `TMC_IO_RST;
                end
            end
            case (wr_state)
                ST_IDLE: begin
                    if (S_AXI_AWVALID && !aw_held) begin
                        aw_held <= 1'b1;
                        aw_addr <= S_AXI_AWADDR;
                    end
                    if (S_AXI_WVALID && !w_held) begin
                        w_held <= 1'b1;
                        w_data <= S_AXI_WDATA;
                        w_strb <= S_AXI_WSTRB;
                    end
                    if (wr_go) begin
                        wr_state <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    aw_held      <= 1'b0;
                    w_held       <= 1'b0;
                    S_AXI_BVALID <= 1'b1;
                    S_AXI_BRESP  <= (mapped(aw_addr) && aw_addr != `TMC_OFS_STATUS4)
                                    ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
                    if (mapped(aw_addr) && w_strb[0] && !STANDBY) begin
                        if (aw_addr <= `TMC_OFS_MODE4) begin
                            if (aw_addr[4:2] == 3'h1 || aw_addr[4:2] == 3'h2)
                                mode_store[aw_addr[4:2]] <= {2'h0, w_data[3:0]}; // R7
                            else
                                mode_store[aw_addr[4:2]] <= w_data[5:0]; // R2
                        end else if (aw_addr == `TMC_OFS_CLKSEL4) begin
                            count_source_sel <= w_data[2:0];
                        end else if (aw_addr == `TMC_OFS_STATUS4) begin
                            count_source_sel <= count_source_sel;
                        end else if (is_io_high_slot(aw_addr)) begin
                            io_high[io_chan(aw_addr)] <= w_data[7:0]; // R15
                        end else begin
                            io_low[io_chan(aw_addr)] <= w_data[7:0]; // R15
                        end
                    end
                    wr_state <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (S_AXI_BREADY) begin
                        S_AXI_BVALID <= 1'b0;
                        wr_state     <= ST_IDLE;
                    end
                end
                default: begin
                    wr_state <= ST_IDLE;
                end
            endcase
        end
    end

    // Read path: one cycle after the address is taken.
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0;
            S_AXI_RRESP  <= `TMC_RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_ARVALID && !S_AXI_RVALID) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= mapped(S_AXI_ARADDR) ? read_value(S_AXI_ARADDR) : 32'h0;
                S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Channel four count source: prescaler and synchronised external edges.
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_a_sync     <= 2'h0;
            ext_b_sync     <= 2'h0;
            ext_a_prev     <= 1'b0;
            ext_b_prev     <= 1'b0;
            presc_cnt      <= 10'h0;
            CH4_COUNT_TICK <= 1'b0;
        end else if (CLK_EN) begin
            ext_a_sync <= {ext_a_sync[0], EXT_COUNT_IN_A};
            ext_b_sync <= {ext_b_sync[0], EXT_COUNT_IN_B};
            ext_a_prev <= ext_a_sync[1];
            ext_b_prev <= ext_b_sync[1];
            presc_cnt  <= presc_cnt + 10'h1;
            case (count_source_sel) // R1
                3'h0:    CH4_COUNT_TICK <= 1'b1;
                3'h1:    CH4_COUNT_TICK <= (presc_cnt[1:0] == 2'h3);
                3'h2:    CH4_COUNT_TICK <= (presc_cnt[3:0] == 4'hF);
                3'h3:    CH4_COUNT_TICK <= (presc_cnt[5:0] == 6'h3F);
                3'h4:    CH4_COUNT_TICK <= (presc_cnt[7:0] == 8'hFF);
                3'h5:    CH4_COUNT_TICK <= (presc_cnt == 10'h3FF);
                3'h6:    CH4_COUNT_TICK <= ext_a_sync[1] && !ext_a_prev;
                default: CH4_COUNT_TICK <= ext_b_sync[1] && !ext_b_prev;
            endcase
        end
    end

    // Effective configuration, latched only on channel four count ticks so
    // a change never lands between two counter steps.
    wire        ch3_drives4 = (mode_store[3][3:0] == `TMC_MD_RSYNC) ||
                              (mode_store[3][3:0] >= `TMC_MD_CPWM1); // R13
    reg  [3:0]  md [0:4];
    reg  [1:0]  bf [0:4];
    integer     c;
    integer     k;

    // Mode and buffer bits in effect; channel four takes channel three's when driven.
    always @* begin
        for (k = 0; k < 5; k = k + 1) begin
            md[k] = mode_store[k][3:0];
            bf[k] = mode_store[k][5:4];
        end
        if (ch3_drives4) begin
            md[4] = mode_store[3][3:0]; // R13
            bf[4] = mode_store[3][5:4];
        end
    end

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            EFF_FUNC      <= 80'h0;
            MATCH_ALLOWED <= 20'h0;
            CLEAR_ALLOWED <= 20'h0;
            CH_PWM        <= 5'h0;
            CH_PHASE      <= 5'h0;
            CH_CPWM       <= 5'h0;
            CH4_EFF_MODE  <= `TMC_MD_NORMAL;
            CH4_EFF_BUF   <= 2'h0;
        end else if (CLK_EN && CH4_COUNT_TICK) begin // R22
            for (c = 0; c < 5; c = c + 1) begin
                CH_PWM[c]   <= (md[c] == `TMC_MD_PWM1) || (md[c] == `TMC_MD_PWM2) ||
                               (md[c] == `TMC_MD_RSYNC); // R8
                CH_PHASE[c] <= (md[c][3:2] == 2'h1); // R8
                CH_CPWM[c]  <= (md[c] >= `TMC_MD_CPWM1); // R9
                // Bit 3 of each code picks capture over compare.
                EFF_FUNC[c*16 +: 8]    <= io_high[c]; // R17 R20
                EFF_FUNC[c*16+8 +: 4]  <= bf[c][0] ? 4'h0 : io_low[c][3:0]; // R18 R19
                EFF_FUNC[c*16+12 +: 4] <= bf[c][1] ? 4'h0 : io_low[c][7:4]; // R18 R19
                MATCH_ALLOWED[c*4 +: 4] <= {~bf[c][1], ~bf[c][0], 2'h3}; // R5 R6
                CLEAR_ALLOWED[c*4 +: 4] <= {~bf[c][1], ~bf[c][0], 2'h3}; // R21
            end
            CH4_EFF_MODE <= md[4];
            CH4_EFF_BUF  <= bf[4];
        end
    end

endmodule

/* verification/timer_mode_io_control_tb.sv */
`timescale 1ns/100ps
`include "tmc_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module timer_mode_io_control_tb;
    logic        clk, rst_n, stby, awv, wv, bready, arv, rready, ext_en, cen;
    logic [3:0]  wstrb;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    wire         awr, wr_rdy, bv, arr, rv, tick, pin_a, pin_b;
    wire  [1:0]  bresp, rresp, ebuf;
    wire  [31:0] rdata;
    wire  [3:0]  emode;
    wire  [79:0] efunc;
    wire  [19:0] match, clr;
    wire  [4:0]  pwm, phase, cpwm;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    logic [7:0]  regs [13] = '{`TMC_OFS_MODE0, `TMC_OFS_MODE1, `TMC_OFS_MODE2, `TMC_OFS_MODE3,
        `TMC_OFS_MODE4, `TMC_OFS_IOH0, `TMC_OFS_IOL0, `TMC_OFS_IO1, `TMC_OFS_IO2,
        `TMC_OFS_IOH3, `TMC_OFS_IOL3, `TMC_OFS_IOH4, `TMC_OFS_IOL4};
    // Only codes legal on channel three; reserved codes are never written.
    logic [3:0]  codes [6] = '{4'h0, 4'h2, 4'h8, 4'hD, 4'hE, 4'hF};
    tmc_top dut (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(cen), .STANDBY(stby),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
        .EXT_COUNT_IN_A(pin_a), .EXT_COUNT_IN_B(pin_b), .CH4_COUNT_TICK(tick),
        .CH4_EFF_MODE(emode), .CH4_EFF_BUF(ebuf), .EFF_FUNC(efunc), .MATCH_ALLOWED(match),
        .CLEAR_ALLOWED(clr), .CH_PWM(pwm), .CH_PHASE(phase), .CH_CPWM(cpwm));
    tmc_ext_src #(.HALF_A(33.0), .HALF_B(81.0)) ext (.en(ext_en), .pin_a(pin_a), .pin_b(pin_b));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            $display("wrong value at %0t: timeout", $time);
            test_done();
        end
    end
    task wr(input [7:0] a, input [7:0] d, input [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 100);
        bready <= 1'b0;
        `CHK(bv, 1'b1)
        `CHK(bresp, er)
    endtask
    task rd(input [7:0] a, input [7:0] e, input [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 100);
        rready <= 1'b0;
        `CHK(rv, 1'b1)
        `CHK(rdata, {24'h0, e})
        `CHK(rresp, er)
    endtask
    task settle;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        int n, e;
        {rst_n, stby, awv, wv, bready, arv, rready, ext_en} = 8'h00;
        {awaddr, araddr, wdata} = 48'h0;
        cen = 1'b1;
        wstrb = 4'hF;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        for (int i = 0; i < 13; i++)
            rd(regs[i], i < 5 ? `TMC_MODE_RST : `TMC_IO_RST, `TMC_RESP_OKAY);
        for (int i = 5; i < 13; i++) begin
            wr(regs[i], 8'hA5 ^ i[7:0], `TMC_RESP_OKAY);
            rd(regs[i], 8'hA5 ^ i[7:0], `TMC_RESP_OKAY);
        end
        $display("test reset values done");
        wr(`TMC_OFS_IOL0, 8'hAB, `TMC_RESP_OKAY);
        wr(`TMC_OFS_IOL3, 8'hCD, `TMC_RESP_OKAY);
        for (int i = 0; i < 5; i += 3) wr(regs[i], 8'h30, `TMC_RESP_OKAY);
        wr(`TMC_OFS_MODE4, 8'h30, `TMC_RESP_OKAY);
        rd(`TMC_OFS_MODE0, 8'hF0, `TMC_RESP_OKAY);
        settle;
        `CHK(efunc[15:8], 8'h00)
        `CHK(match[3:2], 2'b00)
        `CHK(clr[3:2], 2'b00)
        `CHK(efunc[63:56], 8'h00)
        `CHK(match[19:18], 2'b00)
        wr(`TMC_OFS_MODE0, 8'h00, `TMC_RESP_OKAY);
        rd(`TMC_OFS_MODE0, 8'hC0, `TMC_RESP_OKAY);
        settle;
        `CHK(efunc[15:8], 8'hAB)
        `CHK(match[3:2], 2'b11)
        wr(`TMC_OFS_MODE1, 8'h34, `TMC_RESP_OKAY);
        rd(`TMC_OFS_MODE1, 8'hC4, `TMC_RESP_OKAY);
        wr(`TMC_OFS_IO1, 8'h9C, `TMC_RESP_OKAY);
        wr(`TMC_OFS_MODE2, 8'h03, `TMC_RESP_OKAY);
        rd(`TMC_OFS_MODE2, 8'hC3, `TMC_RESP_OKAY);
        settle;
        `CHK(phase[1], 1'b1)
        `CHK(efunc[23:16], 8'h9C)
        `CHK(efunc[23], 1'b1)
        `CHK(pwm[2], 1'b1)
        wstrb <= 4'h0;
        wr(`TMC_OFS_IO1, 8'h11, `TMC_RESP_OKAY);
        wstrb <= 4'hF;
        rd(`TMC_OFS_IO1, 8'h9C, `TMC_RESP_OKAY);
        $display("test buffer and fields done");
        wr(`TMC_OFS_MODE4, 8'h22, `TMC_RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            wr(`TMC_OFS_MODE3, {4'h0, codes[i]}, `TMC_RESP_OKAY);
            rd(`TMC_OFS_MODE3, {4'hC, codes[i]}, `TMC_RESP_OKAY);
            settle;
            `CHK(cpwm[3], codes[i] >= 4'hD)
            `CHK(emode, codes[i][3] ? codes[i] : 4'h2)
            `CHK(ebuf, codes[i][3] ? 2'b00 : 2'b10)
        end
        wr(`TMC_OFS_MODE3, 8'h00, `TMC_RESP_OKAY);
        rd(8'h14, 8'h00, `TMC_RESP_SLVERR);
        wr(8'h14, 8'h55, `TMC_RESP_SLVERR);
        wr(`TMC_OFS_STATUS4, 8'h00, `TMC_RESP_SLVERR);
        cen <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK({awr, wr_rdy, arr}, 3'b000)
        cen <= 1'b1;
        $display("test modes done");
        wr(`TMC_OFS_MODE0, 8'h32, `TMC_RESP_OKAY);
        stby <= 1'b1;
        repeat (4) @(posedge clk);
        wr(`TMC_OFS_MODE0, 8'h02, `TMC_RESP_OKAY);
        stby <= 1'b0;
        rd(`TMC_OFS_MODE0, 8'hC0, `TMC_RESP_OKAY);
        rd(`TMC_OFS_IOL0, 8'h00, `TMC_RESP_OKAY);
        $display("test standby done");
        ext_en <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(`TMC_OFS_CLKSEL4, k[7:0], `TMC_RESP_OKAY);
            settle;
            n = 0;
            repeat (4096) @(posedge clk) if (tick === 1'b1) n++;
            e = (k == 6) ? 248 : 101;
            if (k < 6) `CHK(n, 4096 >> (2 * k))
            else `CHK((n > e - 3) && (n < e + 3), 1'b1)
        end
        $display("test clock select done");
        test_done();
    end
endmodule
bind tmc_top tmc_monitor mon (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RDATA(S_AXI_RDATA), .CH4_EFF_MODE(CH4_EFF_MODE), .CH4_EFF_BUF(CH4_EFF_BUF),
    .EFF_FUNC(EFF_FUNC), .MATCH_ALLOWED(MATCH_ALLOWED), .CLEAR_ALLOWED(CLEAR_ALLOWED),
    .CH_CPWM(CH_CPWM));

/* verification/tmc_ext_src.sv */
`timescale 1ns/100ps
module tmc_ext_src #(
    parameter real HALF_A = 33.0,
    parameter real HALF_B = 81.0
) (
    // Run control.
    input  wire  en,
    // External count pins.
    output logic pin_a,
    output logic pin_b
);
    // Pins rest low while disabled, so no stray edge reaches the counter.
    initial begin
        pin_a = 1'b0;
        // Half-step offset keeps pin edges away from the sampling clock edges.
        #0.5;
        forever #(HALF_A) pin_a = en ? ~pin_a : 1'b0;
    end
    initial begin
        pin_b = 1'b0;
        #0.5;
        forever #(HALF_B) pin_b = en ? ~pin_b : 1'b0;
    end
endmodule

/* verification/tmc_monitor.sv */
`timescale 1ns/100ps
module tmc_monitor (
    // Clock and reset.
    input wire        REF_CLK,
    input wire        RESET_N,
    // Bus handshakes.
    input wire        S_AXI_AWVALID,
    input wire        S_AXI_AWREADY,
    input wire        S_AXI_BVALID,
    input wire        S_AXI_ARVALID,
    input wire        S_AXI_ARREADY,
    input wire        S_AXI_RVALID,
    input wire [31:0] S_AXI_RDATA,
    // Effective configuration.
    input wire [3:0]  CH4_EFF_MODE,
    input wire [1:0]  CH4_EFF_BUF,
    input wire [79:0] EFF_FUNC,
    input wire [19:0] MATCH_ALLOWED,
    input wire [19:0] CLEAR_ALLOWED,
    input wire [4:0]  CH_CPWM
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    sequence aw_taken;
        S_AXI_AWVALID && S_AXI_AWREADY;
    endsequence
    sequence ar_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    wr_answer_a: assert property (aw_taken |-> ##[1:6] S_AXI_BVALID)
        else $error("write response missing");
    rd_answer_a: assert property (ar_taken |=> S_AXI_RVALID)
        else $error("read data late");
    rd_upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("read upper bits set");
    buf_c_func_a: assert property (!MATCH_ALLOWED[2] |-> EFF_FUNC[11:8] == 4'h0)
        else $error("buffer C keeps function");
    buf_d_func_a: assert property (!MATCH_ALLOWED[15] |-> EFF_FUNC[63:60] == 4'h0)
        else $error("buffer D keeps function");
    buf_no_clear_a: assert property (!MATCH_ALLOWED[2] |-> !CLEAR_ALLOWED[2])
        else $error("buffer C clears counter");
    follow_ch3_a: assert property (CH_CPWM[3] |-> CH4_EFF_MODE inside {4'hD, 4'hE, 4'hF})
        else $error("channel four not following");
    ch4_buf_d_a: assert property (CH4_EFF_BUF[1] |-> !MATCH_ALLOWED[19])
        else $error("channel four D still matches");
endmodule
